// ==== logic/cib_bus_port.sv ====
// Operation
// RL1 - Code 000 is no action; data lines stay released.
// RL2 - Code 001: acknowledged device drives its interrupt vector.
// RL3 - Code 010: addressed device supplies the address word.
// RL4 - Code 011: selected device drives addressed register contents.
// RL5 - Code 100: capture address from data lines for later cycles.
// RL6 - Code 110 carries write data; code 101 strobes it in.
// RL7 - Data lines released except when sending data or status.
// RL8 - Eight data lines are the low byte, address and data.
// RL9 - Phase-one clock marks when the bus code is valid.
// RL10 - Phase-one clock also steps the sixteen-bit timer.
// RL11 - Reads and writes only while chip select is asserted.
// RL12 - Interrupt request is open drain, pulled low to request.
// RL13 - Mask in and mask out form a priority daisy chain.
// RL14 - Highest-priority device has its mask in tied to ground.
// RL15 - Terminate pulse ends the interrupt service in progress.
// RL16 - Two eight-bit buffer registers hold written data.
// RL17 - Three vector registers: input/output, error and timer.
// RL18 - Vectors loaded after power clear, rewritable at any time.
// RL19 - Three interrupt priority levels among the sources.
// RL20 - Parity computed on each peripheral byte.
// RL21 - Peripheral lines read as line level, wire-ORed.
// RL22 - Parity bit reads 0 for even, 1 for odd.
// RL23 - Data buffers at offsets one and two; high byte at two.
// RL24 - Error summary highest priority, timer lowest.
// RL25 - On acknowledge request only if mask in low; raise mask out.
`timescale 1ns/1ps
`include "cib_map.svh"
module cib_bus_port (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic power_clear_n_i,
  input wire logic phase_one_clock_n_i,
  input wire logic bus_direction_line_i,
  input wire logic bus_control_one_i,
  input wire logic bus_control_two_i,
  input wire logic chip_select_n_i,
  input wire logic [7:0] host_data_lines_i,
  output logic [7:0] host_data_lines_o,
  output logic host_data_lines_oe_o,
  input wire logic terminate_interrupt_n_i,
  output logic interrupt_request_n_o,
  output logic interrupt_request_n_oe_o,
  input wire logic priority_mask_in_i,
  output logic priority_mask_out_o,
  input wire logic [15:0] peripheral_lines_i,
  output logic [15:0] peripheral_lines_o,
  output logic peripheral_enable_o,
  input wire logic attention_request_n_i,
  input wire logic error_n_i
);
  logic rst;
  logic strobe;
  logic ar_fall;
  logic tci_fall;
  cib_pkg::cib_bus_state_type cur;
  logic [2:0] addr;
  logic sel;
  logic [7:0] wdata;
  logic [7:0] data_lo;
  logic [7:0] data_hi;
  logic tce;
  logic tie;
  logic pie;
  logic dwsl;
  logic ready;
  logic [7:0] vec_io;
  logic [7:0] vec_err;
  logic [7:0] vec_tmr;
  logic tmr_flag;
  logic in_service;
  logic vec_due;
  cib_pkg::cib_source_type src_ack;
  cib_pkg::cib_source_type src_next;
  logic [15:0] tmr_count;
  logic tmr_end;

  // Power clear acts like the synchronous reset
  assign rst = srst_i | ~power_clear_n_i;

  // RL9 - strobe on phase one
  cib_fall_det #(.IDLE_LEVEL(1'b1)) u_ck1 (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst),
    .level_i(phase_one_clock_n_i),
    .fall_o(strobe)
  );

  cib_fall_det #(.IDLE_LEVEL(1'b1)) u_ar (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst),
    .level_i(attention_request_n_i),
    .fall_o(ar_fall)
  );

  // RL15 - terminate pulse edge
  cib_fall_det #(.IDLE_LEVEL(1'b1)) u_tci (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst),
    .level_i(terminate_interrupt_n_i),
    .fall_o(tci_fall)
  );

  // RL9 - decode the bus code
  assign cur = cib_pkg::cib_bus_state_type'({bus_direction_line_i,
    bus_control_one_i, bus_control_two_i});

  wire st_vec = strobe & (cur == cib_pkg::vector_to_bus_state);
  wire st_bar = strobe & (cur == cib_pkg::address_capture_state);
  wire st_dw = strobe & (cur == cib_pkg::write_data_state);
  wire st_ack = strobe & (cur == cib_pkg::interrupt_ack_state);
  // RL3 - indirect load answers like a read
  wire st_rd = strobe & ((cur == cib_pkg::read_to_bus_state) |
    (cur == cib_pkg::indirect_address_load_state));
  wire st_dws = strobe & (cur == cib_pkg::write_strobe_state);

  // RL11 - accesses gated by captured select
  wire do_write = st_dws & sel;
  wire do_read = st_rd & sel;

  // Address decoding
  wire hit_ctrl = (addr == `CIB_OFS_CTRL);
  wire hit_dlo = (addr == `CIB_OFS_DATA_LO);
  wire hit_dhi = (addr == `CIB_OFS_DATA_HI);
  wire hit_tlo = (addr == `CIB_OFS_TMR_LO);
  wire hit_thi = (addr == `CIB_OFS_TMR_HI);
  wire hit_vio = (addr == `CIB_OFS_VEC_IO);
  wire hit_verr = (addr == `CIB_OFS_VEC_ERR);
  wire hit_vtmr = (addr == `CIB_OFS_VEC_TMR);

  // Handshake restarts on the byte that completes a word
  wire hit_last = dwsl ? hit_dhi : hit_dlo;
  wire data_touch = (do_write | do_read) & hit_last;

  // RL20 - byte parity
  // RL21 - from the line levels
  // RL22 - odd reads one
  wire par_lo = ^peripheral_lines_i[7:0];
  wire par_hi = ^peripheral_lines_i[15:8];

  wire [7:0] ctrl_rd = {par_lo, par_hi, tce, tie, pie, dwsl,
    error_n_i, ready};

  // RL21 - reads return line level
  // RL23 - high byte at offset two
  wire [7:0] rd_mux = hit_ctrl ? ctrl_rd :
    hit_dlo ? peripheral_lines_i[7:0] :
    hit_dhi ? peripheral_lines_i[15:8] :
    hit_tlo ? tmr_count[7:0] :
    hit_thi ? tmr_count[15:8] :
    hit_vio ? vec_io :
    hit_verr ? vec_err : vec_tmr;

  // RL24 - error first, timer last
  // RL19 - three levels
  wire pend_err = pie & ~error_n_i;
  wire pend_io = pie & ready;
  wire pend_tmr = tie & tce & tmr_flag;
  assign src_next = pend_err ? cib_pkg::src_err :
    pend_io ? cib_pkg::src_io :
    pend_tmr ? cib_pkg::src_tmr : cib_pkg::src_none;
  wire req_any = (src_next != cib_pkg::src_none);

  // RL13 - requests only when chain is open
  wire req_live = req_any & ~priority_mask_in_i & ~in_service;
  // RL25 - acknowledge only with mask in low
  wire ack = st_ack & req_live;

  // RL17 - vector of the acknowledged source
  wire [7:0] vec_sel = (src_ack == cib_pkg::src_err) ? vec_err :
    (src_ack == cib_pkg::src_io) ? vec_io : vec_tmr;

  // RL10 - timer stepped by phase one
  cib_timer u_tmr (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst),
    .tick_i(strobe),
    .run_i(tce),
    .wr_lo_i(do_write & hit_tlo),
    .wr_hi_i(do_write & hit_thi),
    .data_i(wdata),
    .count_o(tmr_count),
    .end_o(tmr_end)
  );

  // RL5 - address and select captured
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      addr <= 3'h0;
      sel <= 1'b0;
    end else if (st_bar) begin
      addr <= host_data_lines_i[2:0];
      sel <= ~chip_select_n_i;
    end
  end

  // RL6 - data phase holds the byte
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      wdata <= 8'h00;
    end else if (st_dw) begin
      wdata <= host_data_lines_i;
    end
  end

  // RL16 - buffers hold until overwritten
  // RL6 - strobe commits the byte
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      data_lo <= `CIB_DATA_RST;
      data_hi <= `CIB_DATA_RST;
    end else begin
      if (do_write & hit_dlo) begin
        data_lo <= wdata;
      end
      if (do_write & hit_dhi) begin
        data_hi <= wdata;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      tce <= 1'b0;
      tie <= 1'b0;
      pie <= 1'b0;
      dwsl <= 1'b0;
    end else if (do_write & hit_ctrl) begin
      tce <= wdata[`CIB_CTL_TCE];
      tie <= wdata[`CIB_CTL_TIE];
      pie <= wdata[`CIB_CTL_PIE];
      dwsl <= wdata[`CIB_CTL_DWSL];
    end
  end

  // RL18 - vectors writable at any time
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      vec_io <= `CIB_VEC_RST;
      vec_err <= `CIB_VEC_RST;
      vec_tmr <= `CIB_VEC_RST;
    end else begin
      if (do_write & hit_vio) begin
        vec_io <= wdata;
      end
      if (do_write & hit_verr) begin
        vec_err <= wdata;
      end
      if (do_write & hit_vtmr) begin
        vec_tmr <= wdata;
      end
    end
  end

  // Attention edge wins over the clearing access
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      ready <= `CIB_RDY_RST;
    end else if (ar_fall) begin
      ready <= 1'b1;
    end else if (data_touch) begin
      ready <= 1'b0;
    end
  end

  // End of count wins over the service clear
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      tmr_flag <= 1'b0;
    end else if (tmr_end) begin
      tmr_flag <= 1'b1;
    end else if (tci_fall & in_service &
                 (src_ack == cib_pkg::src_tmr)) begin
      tmr_flag <= 1'b0;
    end
  end

  // RL15 - terminate closes service
  // RL25 - acknowledge opens it
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      in_service <= 1'b0;
      src_ack <= cib_pkg::src_none;
    end else if (tci_fall) begin
      in_service <= 1'b0;
    end else if (ack) begin
      in_service <= 1'b1;
      src_ack <= src_next;
    end
  end

  // One vector per acknowledge, so a later chain answer is not hit
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      vec_due <= 1'b0;
    end else if (ack) begin
      vec_due <= 1'b1;
    end else if (st_vec) begin
      vec_due <= 1'b0;
    end
  end

  // RL1 - idle releases
  // RL7 - drive only read or vector
  // RL2 - vector onto the bus
  // RL4 - read data onto the bus
  // RL8 - low byte only
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      host_data_lines_oe_o <= 1'b0;
      host_data_lines_o <= 8'h00;
    end else if (strobe) begin
      host_data_lines_oe_o <= do_read | (st_vec & vec_due);
      host_data_lines_o <= st_vec ? vec_sel : rd_mux;
    end else if (cur == cib_pkg::idle_state) begin
      // Let go before the next address phase
      host_data_lines_oe_o <= 1'b0;
    end
  end

  // RL12 - open drain, pulls low
  // RL13 - mask out blocks lower devices
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      interrupt_request_n_o <= 1'b0;
      interrupt_request_n_oe_o <= 1'b0;
      priority_mask_out_o <= 1'b0;
    end else begin
      interrupt_request_n_o <= 1'b0;
      interrupt_request_n_oe_o <= req_live;
      priority_mask_out_o <= priority_mask_in_i | in_service | req_any;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      peripheral_lines_o <= {`CIB_DATA_RST, `CIB_DATA_RST};
      peripheral_enable_o <= ~`CIB_RDY_RST;
    end else begin
      peripheral_lines_o <= {data_hi, data_lo};
      peripheral_enable_o <= ~ready;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst);

  chk_idle_release: assert property ( // RL1
    strobe && cur == cib_pkg::idle_state |=> !host_data_lines_oe_o)
    else $error("data lines driven after idle code");

  chk_vector_drive: assert property ( // RL2
    st_vec && vec_due |=> host_data_lines_oe_o &&
      host_data_lines_o == $past(vec_sel))
    else $error("vector not driven on vector code");

  chk_ctrl_read: assert property ( // RL4
    do_read && hit_ctrl |=> host_data_lines_oe_o &&
      host_data_lines_o == $past(ctrl_rd))
    else $error("control read wrong");

  chk_addr_capture: assert property ( // RL5
    st_bar |=> addr == $past(host_data_lines_i[2:0]))
    else $error("address not captured");

  chk_vector_write: assert property ( // RL6
    do_write && hit_vio |=> vec_io == $past(wdata))
    else $error("vector write lost");

  chk_unselected_write: assert property ( // RL11
    st_dws && !sel |=> $stable(data_lo) && $stable(data_hi))
    else $error("unselected write changed buffer");

  chk_error_first: assert property ( // RL24
    ack && pend_err |=> src_ack == cib_pkg::src_err)
    else $error("error source not first");

  chk_tci_end: assert property ( // RL15
    tci_fall && in_service |=> !in_service ##1 !host_data_lines_oe_o
      || in_service)
    else $error("service not ended");

  chk_parity_low: assert property ( // RL22
    do_read && hit_ctrl |=>
      host_data_lines_o[`CIB_CTL_PAR_LO] == $past(^peripheral_lines_i[7:0]))
    else $error("low parity wrong");

  chk_mask_out: assert property ( // RL13
    in_service |=> priority_mask_out_o)
    else $error("mask out low in service");

  chk_masked_request: assert property ( // RL25
    priority_mask_in_i |=> !interrupt_request_n_oe_o)
    else $error("request despite mask in");

endmodule

// ==== logic/cib_map.svh ====
`ifndef CIB_MAP_SVH
`define CIB_MAP_SVH

// Register offsets, low three address bits
`define CIB_OFS_CTRL 3'h0
`define CIB_OFS_DATA_LO 3'h1
`define CIB_OFS_DATA_HI 3'h2
`define CIB_OFS_TMR_LO 3'h3
`define CIB_OFS_TMR_HI 3'h4
`define CIB_OFS_VEC_IO 3'h5
`define CIB_OFS_VEC_ERR 3'h6
`define CIB_OFS_VEC_TMR 3'h7

// Control register fields
`define CIB_CTL_PAR_LO 7
`define CIB_CTL_PAR_HI 6
`define CIB_CTL_TCE 5
`define CIB_CTL_TIE 4
`define CIB_CTL_PIE 3
`define CIB_CTL_DWSL 2
`define CIB_CTL_ERR 1
`define CIB_CTL_RDY 0

// Reset values
`define CIB_VEC_RST 8'h00
`define CIB_DATA_RST 8'hFF
`define CIB_TMR_RST 16'hFFFF
`define CIB_RDY_RST 1'h1

// Timer steps once per eight phase-one strobes
`define CIB_TMR_DIV_LAST 3'h7

`endif

// ==== logic/cib_pkg.sv ====
package cib_pkg;

  typedef enum logic [2:0] {
    idle_state = 3'b000,
    vector_to_bus_state = 3'b001,
    indirect_address_load_state = 3'b010,
    read_to_bus_state = 3'b011,
    address_capture_state = 3'b100,
    write_strobe_state = 3'b101,
    write_data_state = 3'b110,
    interrupt_ack_state = 3'b111
  } cib_bus_state_type;

  typedef enum logic [1:0] {
    src_none = 2'b00,
    src_err = 2'b01,
    src_io = 2'b10,
    src_tmr = 2'b11
  } cib_source_type;

endpackage

// ==== logic/cib_fall_det.sv ====
`timescale 1ns/1ps
module cib_fall_det #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic level_i,
  output logic fall_o
);
  logic prev;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prev <= IDLE_LEVEL;
    end else begin
      prev <= level_i;
    end
  end
  assign fall_o = prev & ~level_i;
endmodule

// ==== logic/cib_timer.sv ====
`timescale 1ns/1ps
`include "cib_map.svh"
module cib_timer (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic [7:0] data_i,
  output logic [15:0] count_o,
  output logic end_o
);
  logic [2:0] div;
  logic step;
  // Prescaler holds while disabled so no stray step
  assign step = tick_i & run_i & (div == `CIB_TMR_DIV_LAST);
  assign end_o = step & (count_o == 16'h0001);
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      div <= 3'h0;
      count_o <= `CIB_TMR_RST;
    end else begin
      if (tick_i & run_i) begin
        div <= div + 3'h1;
      end
      if (wr_lo_i) begin
        count_o <= {count_o[15:8], data_i};
      end else if (wr_hi_i) begin
        count_o <= {data_i, count_o[7:0]};
      end else if (step) begin
        count_o <= count_o - 16'h0001;
      end
    end
  end
endmodule

// ==== sim/cib_cpu_model.sv ====
`timescale 1ns/1ps
module cib_cpu_model (
  input wire logic ref_clk_i,
  output logic phase_n_o,
  output logic [2:0] code_o,
  output logic [7:0] data_o,
  output logic term_n_o
);
  logic [7:0] last;

  initial begin
    phase_n_o = 1'b1;
    code_o = 3'h0;
    last = 8'h00;
    data_o = 8'hFF;
    term_n_o = 1'b1;
  end

  task automatic step(input logic [2:0] code, input logic [7:0] d);
    @(posedge ref_clk_i);
    phase_n_o <= 1'b0;
    code_o <= code;
    // drive only for address, write data and write strobe codes
    if (code[2] && code != 3'h7) begin
      data_o <= d;
      last = d;
    end else begin
      data_o <= ~last;
    end
    @(posedge ref_clk_i);
    phase_n_o <= 1'b1;
    code_o <= 3'h0;
    // Released lines flip so stale data never looks valid
    data_o <= ~last;
  endtask

  task automatic term();
    @(posedge ref_clk_i);
    term_n_o <= 1'b0;
    @(posedge ref_clk_i);
    term_n_o <= 1'b1;
  endtask
endmodule

// ==== sim/cpu_io_buffer_bus_interface_tb.sv ====
`timescale 1ns/1ps
module cpu_io_buffer_bus_interface_tb;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic cs_n = 1'b0;
  logic att_n = 1'b1;
  logic err_n = 1'b1;
  logic mask_in = 1'b0;
  logic [15:0] pull = 16'hFFFF;
  logic phase_n, term_n, d_oe, irq_n, irq_oe, mask_out, pen;
  logic [2:0] code;
  logic [7:0] cpu_d, d_o;
  logic [15:0] p_o;
  logic [8:0] v;
  int error_cnt = 0;
  int n_compared = 0;
  logic [7:0] ofs [8] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h02, 8'h01};
  logic [7:0] rst_v [8] = '{8'h03, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'hFF};
  logic [7:0] vec [3] = '{8'h51, 8'h62, 8'h73};
  wire [7:0] bus = d_oe ? d_o : cpu_d;
  // Weak-high drive wire-ANDed with the peripheral pulling low
  wire [15:0] p_in = p_o & pull;

  always #25 ref_clk_i = ~ref_clk_i;

  cib_cpu_model i_cpu (
    .ref_clk_i(ref_clk_i),
    .phase_n_o(phase_n),
    .code_o(code),
    .data_o(cpu_d),
    .term_n_o(term_n)
  );

  cib_bus_port i_dut (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .power_clear_n_i(1'b1),
    .phase_one_clock_n_i(phase_n),
    .bus_direction_line_i(code[2]),
    .bus_control_one_i(code[1]),
    .bus_control_two_i(code[0]),
    .chip_select_n_i(cs_n),
    .host_data_lines_i(bus),
    .host_data_lines_o(d_o),
    .host_data_lines_oe_o(d_oe),
    .terminate_interrupt_n_i(term_n),
    .interrupt_request_n_o(irq_n),
    .interrupt_request_n_oe_o(irq_oe),
    .priority_mask_in_i(mask_in),
    .priority_mask_out_o(mask_out),
    .peripheral_lines_i(p_in),
    .peripheral_lines_o(p_o),
    .peripheral_enable_o(pen),
    .attention_request_n_i(att_n),
    .error_n_i(err_n)
  );

  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_cpu.step(3'h4, a);
    i_cpu.step(3'h6, d);
    i_cpu.step(3'h5, d);
  endtask

  // Returns {drive enable, bus level} just after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [2:0] c,
    output logic [8:0] r);
    i_cpu.step(3'h4, a);
    i_cpu.step(c, 8'h00);
    #1 r = {d_oe, bus};
  endtask

  task automatic wait_irq();
    for (int k = 0; k < 40 && irq_oe !== 1'b1; k++) begin
      i_cpu.step(3'h0, 8'h00);
      #1;
    end
    if (irq_oe !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
  endtask

  task automatic ack(input logic [7:0] e);
    i_cpu.step(3'h7, 8'h00);
    i_cpu.step(3'h1, 8'h00);
    #1 chk({d_oe, bus}, {1'b1, e});
    i_cpu.term();
  endtask

  initial begin
    repeat (12) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    #1 chk({pen, irq_oe, mask_out, d_oe, p_o}, 20'h0FFFF);
    for (int i = 0; i < 8; i++) begin
      rd(ofs[i], 3'h3, v);
      chk(v, {1'b1, rst_v[i]});
    end
    i_cpu.step(3'h0, 8'h00);
    @(posedge ref_clk_i);
    #1 chk({d_oe, pen}, 2'b01);
    for (int i = 0; i < 3; i++) wr(8'h05 + 8'(i), vec[i]);
    for (int i = 0; i < 3; i++) begin
      rd(8'h05 + 8'(i), 3'h3, v);
      chk(v, {1'b1, vec[i]});
    end
    rd(8'h05, 3'h2, v);
    chk(v, {1'b1, vec[0]});
    @(posedge ref_clk_i) cs_n <= 1'b1;
    wr(8'h05, 8'hAA);
    rd(8'h05, 3'h3, v);
    chk(v[8], 1'b0);
    @(posedge ref_clk_i) cs_n <= 1'b0;
    rd(8'h05, 3'h3, v);
    chk(v, {1'b1, vec[0]});
    wr(8'h01, 8'h5B);
    wr(8'h02, 8'h3C);
    @(posedge ref_clk_i);
    #1 chk(p_o, 16'h3C5B);
    rd(8'h00, 3'h3, v);
    chk(v, 9'h182);
    @(posedge ref_clk_i) pull <= 16'hFEFE;
    rd(8'h01, 3'h3, v);
    chk(v, 9'h15A);
    rd(8'h00, 3'h3, v);
    chk(v, 9'h102);
    @(posedge ref_clk_i) pull <= 16'hFFFF;
    wr(8'h00, 8'h08);
    @(posedge ref_clk_i) mask_in <= 1'b1;
    att_n <= 1'b0;
    err_n <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1 chk({irq_oe, mask_out}, 2'b01);
    @(posedge ref_clk_i) mask_in <= 1'b0;
    wait_irq();
    chk({irq_n, mask_out}, 2'b01);
    ack(vec[1]);
    @(posedge ref_clk_i) err_n <= 1'b1;
    att_n <= 1'b1;
    wait_irq();
    ack(vec[0]);
    rd(8'h01, 3'h3, v);
    repeat (4) @(posedge ref_clk_i);
    #1 chk(irq_oe, 1'b0);
    wr(8'h04, 8'h00);
    wr(8'h03, 8'h01);
    wr(8'h00, 8'h38);
    wait_irq();
    ack(vec[2]);
    finish_test();
  end
endmodule
